// >>> hdl/audio_in_pkg.sv
package audio_in_pkg;
  // power-on initialization length in system clocks
  localparam int INIT_CYCLES    = 1024;
  // supported system clock to sample rate ratios
  localparam int RATIO_256      = 256;
  localparam int RATIO_384      = 384;
  localparam int RATIO_512      = 512;
  localparam int RATIO_768      = 768;
  // slack allowed when matching a measured ratio
  localparam int RATIO_TOL      = 8;
  // supported bit clocks per sample period
  localparam int BCK_32         = 32;
  localparam int BCK_48         = 48;
  localparam int BCK_64         = 64;
  // stop detect: bit clock periods without an edge
  localparam int STOP_BITS      = 3;
  // sample periods of mute after resync
  localparam int MUTE_SAMPLES   = 3;
  // stable frames needed before lock
  localparam int LOCK_FRAMES    = 2;
  // default format: 24-bit left-justified
  localparam int SAMPLE_BITS    = 24;
  localparam logic [2:0] FMT_DEFAULT = 3'h0;
  localparam logic [1:0] RATIO_CODE_256 = 2'h0;
  localparam logic [1:0] RATIO_CODE_384 = 2'h1;
  localparam logic [1:0] RATIO_CODE_512 = 2'h2;
  localparam logic [1:0] RATIO_CODE_768 = 2'h3;
  localparam int FIFO_DEPTH     = 32;
  typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_SYNC, ST_RUN} state_t;
endpackage

// >>> hdl/sample_fifo.sv
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sample_fifo

// >>> hdl/dac_audio_front.sv
module dac_audio_front #(
  parameter int SW    = audio_in_pkg::SAMPLE_BITS,
  parameter int DEPTH = audio_in_pkg::FIFO_DEPTH
) (
  // system
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  // serial audio pins
  input  wire logic          SERIAL_BIT_CLOCK,
  input  wire logic          CHANNEL_WORD_CLOCK,
  input  wire logic          SERIAL_DATA,
  // sample stream to the interpolator
  output logic               SAMPLE_VALID,
  input  wire logic          SAMPLE_READY,
  output logic      [SW-1:0] SAMPLE_LEFT,
  output logic      [SW-1:0] SAMPLE_RIGHT,
  // status
  output logic               MUTE,
  output logic               LOCKED,
  output logic               DEFAULTS_LOADED,
  output logic      [1:0]    RATIO_CODE,
  output logic      [2:0]    FORMAT,
  output logic               OVERFLOW
);
  localparam int CW = 11;
  localparam logic [CW-1:0] INIT_LAST = CW'(audio_in_pkg::INIT_CYCLES - 1);
  localparam logic [CW-1:0] FRAME_MAX =
    CW'(audio_in_pkg::RATIO_768 + audio_in_pkg::RATIO_TOL);
  // stop limit: 3 bit periods at the slowest bit clock (768/32 per bit)
  localparam logic [CW-1:0] STOP_LIMIT = CW'(audio_in_pkg::STOP_BITS *
    (audio_in_pkg::RATIO_768 / audio_in_pkg::BCK_32));

  // absolute distance check against a supported ratio
  function automatic logic near(input logic [CW-1:0] v, input int r);
    int d;
    d = int'(v) - r;
    return (d <= audio_in_pkg::RATIO_TOL) && (d >= -audio_in_pkg::RATIO_TOL);
  endfunction

  // three-stage synchronisers; only stages 2 and 3 are compared
  logic [2:0] bck_sync_reg;
  logic [2:0] lr_sync_reg;
  logic [2:0] dat_sync_reg;
  logic       bck_q_reg;
  logic       lr_q_reg;
  logic       dat_q_reg;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      bck_sync_reg <= '0;
      lr_sync_reg  <= '0;
      dat_sync_reg <= '0;
      bck_q_reg    <= 1'b0;
      lr_q_reg     <= 1'b0;
      dat_q_reg    <= 1'b0;
    end
    else
    begin
      bck_sync_reg <= {bck_sync_reg[1:0], SERIAL_BIT_CLOCK};
      lr_sync_reg  <= {lr_sync_reg[1:0], CHANNEL_WORD_CLOCK};
      dat_sync_reg <= {dat_sync_reg[1:0], SERIAL_DATA};
      if (bck_sync_reg[1] == bck_sync_reg[2])
        bck_q_reg <= bck_sync_reg[2];
      if (lr_sync_reg[1] == lr_sync_reg[2])
        lr_q_reg <= lr_sync_reg[2];
      if (dat_sync_reg[1] == dat_sync_reg[2])
        dat_q_reg <= dat_sync_reg[2];
    end
  end

  // bit clock rising edge; data captured here is stable
  wire bck_rise = (bck_sync_reg[2] == bck_sync_reg[1]) &&
                  bck_sync_reg[2] && !bck_q_reg;
  wire dat_now  = (dat_sync_reg[2] == dat_sync_reg[1]) ?
                  dat_sync_reg[2] : dat_q_reg;
  wire lr_now   = (lr_sync_reg[2] == lr_sync_reg[1]) ?
                  lr_sync_reg[2] : lr_q_reg;
  wire lr_edge  = lr_now != lr_q_reg;
  // frame starts at the high-going word clock: left channel
  wire frame_start = lr_edge && lr_now;

  audio_in_pkg::state_t state_reg;
  audio_in_pkg::state_t state_next;
  logic [CW-1:0] init_cnt_reg;
  logic [CW-1:0] frame_cnt_reg;
  logic [CW-1:0] frame_len_reg;
  logic [CW-1:0] idle_cnt_reg;
  logic [1:0]    good_reg;
  logic [1:0]    mute_cnt_reg;
  logic [1:0]    ratio_reg;
  logic [2:0]    fmt_reg;
  logic          loaded_reg;
  logic [SW-1:0] shift_reg;
  logic [5:0]    bits_reg;
  logic [SW-1:0] left_reg;
  logic          pair_valid_reg;

  wire ratio_ok = near(frame_cnt_reg, audio_in_pkg::RATIO_256) ||
                  near(frame_cnt_reg, audio_in_pkg::RATIO_384) ||
                  near(frame_cnt_reg, audio_in_pkg::RATIO_512) ||
                  near(frame_cnt_reg, audio_in_pkg::RATIO_768);
  wire [1:0] ratio_meas =
    near(frame_cnt_reg, audio_in_pkg::RATIO_256) ?
      audio_in_pkg::RATIO_CODE_256 :
    near(frame_cnt_reg, audio_in_pkg::RATIO_384) ?
      audio_in_pkg::RATIO_CODE_384 :
    near(frame_cnt_reg, audio_in_pkg::RATIO_512) ?
      audio_in_pkg::RATIO_CODE_512 : audio_in_pkg::RATIO_CODE_768;
  wire rate_changed = frame_start && (frame_len_reg != '0) &&
    !near(frame_cnt_reg, int'(frame_len_reg));
  wire clock_stop = (idle_cnt_reg >= STOP_LIMIT) ||
                    (frame_cnt_reg >= FRAME_MAX);
  wire disturbed  = rate_changed || clock_stop || (frame_start && !ratio_ok);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      audio_in_pkg::ST_INIT:
        if (init_cnt_reg == INIT_LAST)
          state_next = audio_in_pkg::ST_LOAD;
      audio_in_pkg::ST_LOAD:
        if (frame_start || clock_stop)
          state_next = audio_in_pkg::ST_SYNC;
      audio_in_pkg::ST_SYNC:
        if (disturbed)
          state_next = audio_in_pkg::ST_SYNC;
        else if (frame_start &&
                 good_reg == 2'(audio_in_pkg::LOCK_FRAMES - 1))
          state_next = audio_in_pkg::ST_RUN;
      audio_in_pkg::ST_RUN:
        if (disturbed)
          state_next = audio_in_pkg::ST_SYNC;
      default:
        state_next = audio_in_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_reg    <= audio_in_pkg::ST_INIT;
      init_cnt_reg <= '0;
      loaded_reg   <= 1'b0;
      fmt_reg      <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == audio_in_pkg::ST_INIT)
        init_cnt_reg <= init_cnt_reg + 1'b1;
      if (state_reg == audio_in_pkg::ST_LOAD && state_next != state_reg)
      begin
        loaded_reg <= 1'b1;
        fmt_reg    <= audio_in_pkg::FMT_DEFAULT;
      end
    end
  end

  // frame length measurement and clock watchdog
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      frame_cnt_reg <= '0;
      frame_len_reg <= '0;
      idle_cnt_reg  <= '0;
      good_reg      <= '0;
      ratio_reg     <= audio_in_pkg::RATIO_CODE_256;
    end
    else
    begin
      idle_cnt_reg <= bck_rise ? '0 :
        (clock_stop ? idle_cnt_reg : idle_cnt_reg + 1'b1);
      if (frame_start)
      begin
        frame_cnt_reg <= CW'(1);
        frame_len_reg <= ratio_ok ? frame_cnt_reg : '0;
        if (ratio_ok)
          ratio_reg <= ratio_meas;
      end
      else if (frame_cnt_reg < FRAME_MAX)
        frame_cnt_reg <= frame_cnt_reg + 1'b1;
      if (disturbed || state_reg != audio_in_pkg::ST_SYNC)
        good_reg <= '0;
      else if (frame_start && good_reg != 2'(audio_in_pkg::LOCK_FRAMES))
        good_reg <= good_reg + 1'b1;
    end
  end

  // mute holds through sync and three frames after lock
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      mute_cnt_reg <= 2'(audio_in_pkg::MUTE_SAMPLES);
    else if (state_reg != audio_in_pkg::ST_RUN)
      mute_cnt_reg <= 2'(audio_in_pkg::MUTE_SAMPLES);
    else if (frame_start && mute_cnt_reg != '0)
      mute_cnt_reg <= mute_cnt_reg - 1'b1;
  end

  // shift MSB first; left-justified word starts at the word clock edge
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      shift_reg      <= '0;
      bits_reg       <= '0;
      left_reg       <= '0;
      pair_valid_reg <= 1'b0;
    end
    else
    begin
      pair_valid_reg <= 1'b0;
      if (lr_edge)
      begin
        bits_reg <= '0;
        if (lr_now)
          pair_valid_reg <= (state_reg == audio_in_pkg::ST_RUN);
        else
          left_reg <= shift_reg;
      end
      else if (bck_rise && bits_reg != 6'(SW))
      begin
        shift_reg <= {shift_reg[SW-2:0], dat_now};
        bits_reg  <= bits_reg + 1'b1;
      end
    end
  end

  logic [2*SW-1:0] fifo_out;
  logic            fifo_in_ready;
  sample_fifo #(
    .WIDTH (2*SW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .in_valid  (pair_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   ({left_reg, shift_reg}),
    .out_valid (SAMPLE_VALID),
    .out_ready (SAMPLE_READY),
    .out_data  (fifo_out)
  );

  logic ovf_reg;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      ovf_reg <= 1'b0;
    else if (pair_valid_reg && !fifo_in_ready)
      ovf_reg <= 1'b1;
  end

  wire muted = (state_reg != audio_in_pkg::ST_RUN) || (mute_cnt_reg != '0);
  // midscale is code zero in two's complement
  assign SAMPLE_LEFT     = muted ? '0 : fifo_out[2*SW-1:SW];
  assign SAMPLE_RIGHT    = muted ? '0 : fifo_out[SW-1:0];
  assign MUTE            = muted;
  assign LOCKED          = (state_reg == audio_in_pkg::ST_RUN);
  assign DEFAULTS_LOADED = loaded_reg;
  assign RATIO_CODE      = ratio_reg;
  assign FORMAT          = fmt_reg;
  assign OVERFLOW        = ovf_reg;

  init_mute_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state_reg == audio_in_pkg::ST_INIT) |-> MUTE && SAMPLE_LEFT == '0)
    else $error("output not muted in init");
  init_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(state_reg == audio_in_pkg::ST_LOAD) |->
    $past(init_cnt_reg) == INIT_LAST)
    else $error("init length wrong");
  stop_sync_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (LOCKED && clock_stop) |=> state_reg == audio_in_pkg::ST_SYNC)
    else $error("no suspend on stop");
  sequence lock_seq;
    $rose(LOCKED);
  endsequence
  post_mute_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    lock_seq |-> MUTE)
    else $error("mute dropped at lock");

  // a locked frame start must hand its pair to the fifo
  sequence run_frame_seq;
    LOCKED && frame_start;
  endsequence
  pair_push_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run_frame_seq |=> pair_valid_reg)
    else $error("pair not pushed at frame");

  // watchdog reaches its limit exactly one quiet clock later
  sequence stop_seq;
    (idle_cnt_reg == STOP_LIMIT - 1'b1) && !bck_rise && !frame_start;
  endsequence
  stop_count_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    stop_seq |=> clock_stop)
    else $error("stop not detected");

  // sync state must keep mute set and the right channel at midscale
  sync_mute_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state_reg == audio_in_pkg::ST_SYNC) |-> MUTE && SAMPLE_RIGHT == '0)
    else $error("output not muted in sync");

  // defaults land together with the loaded flag
  fmt_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(DEFAULTS_LOADED) |-> FORMAT == audio_in_pkg::FMT_DEFAULT)
    else $error("format default not loaded");
  run_loaded_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    LOCKED |-> DEFAULTS_LOADED)
    else $error("running before defaults");

  // sound returns only on a frame boundary
  unmute_frame_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(MUTE) |-> $past(frame_start) && LOCKED)
    else $error("unmute off frame boundary");

  // lock is only taken on a frame of a supported ratio
  lock_ratio_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    lock_seq |-> $past(ratio_ok))
    else $error("lock on unsupported ratio");
endmodule // dac_audio_front

// >>> testbench/audio_source.sv
module audio_source (
  // frame control
  input  wire logic       run,
  input  wire logic [6:0] bits,
  // serial audio pins
  output logic            serial_bit_clock,
  output logic            channel_word_clock,
  output logic            sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [47:0] sent_q[$];
  logic [47:0] pair;
  logic [23:0] word;
  int          n;
  int          h;
  int          k;

  // clocks stand still between runs; data flips so no stale level is seen
  initial
  begin
    serial_bit_clock = 1'b0;
    channel_word_clock = 1'b0;
    sdata = 1'b0;
    forever
    begin
      #130;
      sdata = ~sdata;
      while (run === 1'b1)
      begin
        n = int'(bits);
        h = n / 2;
        pair = 48'({$urandom, $urandom});
        sent_q.push_back(pair);
        for (int i = 0; i < n; i++)
        begin
          k = i % h;
          word = (i < h) ? pair[47:24] : pair[23:0];
          serial_bit_clock = 1'b0;
          channel_word_clock = (i < h);
          sdata = (k < 24) ? word[23 - k] : ~sdata;
          #200;
          serial_bit_clock = 1'b1;
          #200;
        end
      end
    end
  end
endmodule // audio_source

// >>> testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk;
  logic        rst_n;
  logic        ready;
  logic        run;
  logic        check_en;
  logic        synced;
  logic [6:0]  bits;
  logic        serial_bit_clock;
  logic        channel_word_clock;
  logic        sdata;
  logic        valid;
  logic        mute;
  logic        locked;
  logic        loaded;
  logic        ovf;
  logic [23:0] left;
  logic [23:0] right;
  logic [1:0]  ratio;
  logic [2:0]  fmt;
  int          num_errors;
  int          checks;
  int          idx;
  int          pops;
  int          mode;

  audio_source audio_source_inst (.run(run), .bits(bits), .serial_bit_clock(serial_bit_clock),
    .channel_word_clock(channel_word_clock), .sdata(sdata));
  dac_audio_front dac_audio_front_inst (.MCLK(mclk), .RST_N(rst_n),
    .SERIAL_BIT_CLOCK(serial_bit_clock), .CHANNEL_WORD_CLOCK(channel_word_clock), .SERIAL_DATA(sdata),
    .SAMPLE_VALID(valid), .SAMPLE_READY(ready), .SAMPLE_LEFT(left),
    .SAMPLE_RIGHT(right), .MUTE(mute), .LOCKED(locked),
    .DEFAULTS_LOADED(loaded), .RATIO_CODE(ratio), .FORMAT(fmt),
    .OVERFLOW(ovf));

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait on a status output, then compare it
  task automatic wait_for(string name, ref logic s, input logic v,
                          input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check(name, s, v);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // consumer: random stalls, held off to fill, or always ready to drain
  always @(posedge mclk)
    ready <= (mode == 2) || (mode == 0 && $urandom_range(1) == 1);

  always @(posedge mclk)
    if (rst_n && valid === 1'b1 && ready)
    begin
      pops++;
      if (check_en && mute === 1'b0)
      begin
        if (!synced)
        begin
          idx = 0;
          while (idx < audio_source_inst.sent_q.size() - 1 &&
                 audio_source_inst.sent_q[idx] !== {left, right})
            idx++;
          synced = 1'b1;
        end
        check("sample", {left, right}, audio_source_inst.sent_q[idx]);
        idx++;
      end
    end

  initial
  begin
    #5000000;
    num_errors++;
    final_report();
  end

  initial
  begin
    void'($urandom(32754));
    rst_n = 1'b0;
    mode = 0;
    run = 1'b0;
    bits = 7'h40;
    check_en = 1'b0;
    synced = 1'b0;
    num_errors = 0;
    checks = 0;
    pops = 0;
    cyc(4);
    check("reset", {valid, locked, loaded, ovf, ratio, fmt, mute}, 10'h001);
    check("left", left, 24'h0);
    rst_n <= 1'b1;
    run <= 1'b1;
    cyc(1000);
    check("init", {mute, loaded}, 2'h2);
    cyc(560);
    check("loaded", {loaded, fmt}, 4'h8);
    wait_for("locked", locked, 1'b1, 4000);
    check("ratio", ratio, audio_in_pkg::RATIO_CODE_512);
    wait_for("mute", mute, 1'b0, 2000);
    check_en = 1'b1;
    cyc(4096);
    check_en = 1'b0;
    synced = 1'b0;
    run <= 1'b0;
    wait_for("stop", locked, 1'b0, 800);
    check("mute", mute, 1'b1);
    cyc(100);
    run <= 1'b1;
    wait_for("relock", locked, 1'b1, 1536);
    cyc(1300);
    check("mute", mute, 1'b1);
    wait_for("unmute", mute, 1'b0, 400);
    for (int j = 0; j < 3; j++)
    begin
      bits <= (j == 0) ? 7'h30 : (j == 1) ? 7'h20 : 7'h40;
      wait_for("rate", locked, 1'b0, 1200);
      wait_for("lock", locked, 1'b1, 2500);
      check("ratio", ratio, (j == 0) ? audio_in_pkg::RATIO_CODE_384 :
        (j == 1) ? audio_in_pkg::RATIO_CODE_256 :
        audio_in_pkg::RATIO_CODE_512);
      if (j != 1)
      begin
        wait_for("unmute", mute, 1'b0, 2000);
        synced = 1'b0;
        check_en = 1'b1;
        cyc(2000);
        check_en = 1'b0;
      end
    end
    mode = 1;
    cyc(18432);
    check("full", {ovf, valid}, 2'h3);
    mode = 2;
    pops = 0;
    cyc(40);
    check("drained", pops >= audio_in_pkg::FIFO_DEPTH, 1'b1);
    mode = 0;
    final_report();
  end
endmodule // testbench
